// >>> src/sensor_spi_device.sv
/*
 * sensor end of the serial port, plus the sample buffer read through the fifo register.
 * assumes link pins are asynchronous to ref_clk and are sampled at least four
 * times per serial clock half period; register contents live outside, except the three-wire bit.
 */
// Behaviour
// - strap low enables serial port, high disables
// - clock pin is serial clock, data pin input
// - starts four-wire, write 0x34 bit selects three-wire
// - clock level at select fall picks mode
// - frame is control byte then data byte
// - master frames with select and drives clock
// - change on falling edge, capture on rising
// - output stays released during writes
// - first bit direction, then seven address bits
// - second byte is write or read data
// - burst reads increment address while selected
// - three-wire uses data pin both ways
// - three-wire drives falling, captures rising
// - same protocol in both wirings
// - burst from fifo register holds address
`timescale 1ns/1ps
module sample_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   // filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0]      count, next_count;
   logic             push, pop;

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // storage carries no reset, so it stays out of the reset process
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule : sample_fifo

module sensor_spi_device #(
   parameter int FIFO_DEPTH = spi_port_pkg::FIFO_DEPTH
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // link
   spi_link.device          link,
   // strap pin
   input  wire logic        interface_select_strap,
   // register access towards the register file
   output logic      [6:0]  reg_addr,
   output logic      [7:0]  reg_wdata,
   output logic             reg_wr,
   output logic             reg_rd,
   input  wire logic [7:0]  reg_rdata,
   // sample stream into the buffer
   input  wire logic        sample_valid,
   output logic             sample_ready,
   input  wire logic [7:0]  sample_data,
   // status
   output logic             spi_selected,
   output logic             three_wire_enable
);
   initial begin
      if (FIFO_DEPTH < 2) $error("fifo depth too small");
   end

   // =========================================================
   // synchronisers: strap, select, clock, data
   logic [3:0] meta, sync;
   logic       strap_s, csn_s, sck_s, sdi_s;
   logic       sck_d;
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         // idle levels, so no false clock edge follows reset
         meta  <= 4'hd;
         sync  <= 4'hd;
         sck_d <= 1'b0;
      end else begin
         meta  <= {interface_select_strap, link.chip_select_n,
                   link.shared_clock_pin, link.shared_data_pin};
         sync  <= meta;
         sck_d <= sck_s;
      end
   end
   assign strap_s = sync[3];
   assign csn_s   = sync[2];
   assign sck_s   = sync[1];
   assign sdi_s   = sync[0];

   // =========================================================
   // sample buffer
   logic       fifo_valid, fifo_pop;
   logic [7:0] fifo_data;
   sample_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) i_sample_fifo (
      .ref_clk   (ref_clk),
      .rstn      (rstn),
      .in_valid  (sample_valid),
      .in_ready  (sample_ready),
      .in_data   (sample_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   // =========================================================
   // frame engine
   spi_port_pkg::dev_phase_e phase, next_phase;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic [7:0] rx, next_rx, tx, next_tx;
   logic [6:0] addr, next_addr;
   logic [7:0] wdata, next_wdata;
   logic       is_read, next_is_read, hold_addr, next_hold_addr;
   logic       fetch, next_fetch, wr_pulse, next_wr_pulse;
   logic       drive, next_drive, out_bit, next_out_bit;
   logic       mode3, next_mode3, three_wire, next_three_wire;
   logic       sck_rise, sck_fall, active;
   logic [7:0] rx_full, rd_val;

   assign spi_selected = !strap_s;
   assign active   = spi_selected && !csn_s;
   assign sck_rise = sck_s && !sck_d;
   assign sck_fall = !sck_s && sck_d;
   assign rx_full  = {rx[6:0], sdi_s};
   assign fifo_pop = fetch && hold_addr && fifo_valid;
   assign reg_rd   = fetch && !hold_addr;

   // read value, with the wiring bit owned here
   always_comb begin
      rd_val = reg_rdata;
      if (hold_addr) begin
         rd_val = fifo_valid ? fifo_data : spi_port_pkg::EMPTY_READ_VAL;
      end else if (addr == spi_port_pkg::THREE_WIRE_ADDR) begin
         rd_val[spi_port_pkg::THREE_WIRE_BIT] = three_wire;
      end
   end

   always_comb begin
      next_phase      = phase;
      next_bit_cnt    = bit_cnt;
      next_rx         = rx;
      next_tx         = tx;
      next_addr       = addr;
      next_wdata      = wdata;
      next_is_read    = is_read;
      next_hold_addr  = hold_addr;
      next_fetch      = 1'b0;
      next_wr_pulse   = 1'b0;
      next_drive      = drive;
      next_out_bit    = out_bit;
      next_mode3      = mode3;
      next_three_wire = three_wire;
      if (fetch) begin
         next_tx = rd_val;
      end
      if (wr_pulse && addr == spi_port_pkg::THREE_WIRE_ADDR) begin
         next_three_wire = wdata[spi_port_pkg::THREE_WIRE_BIT];
      end
      if (!active) begin
         // partial frames are dropped; no write is issued
         next_phase   = spi_port_pkg::PH_IDLE;
         next_bit_cnt = 3'h0;
         next_drive   = 1'b0;
      end else begin
         case (phase)
            spi_port_pkg::PH_IDLE: begin
               next_mode3   = sck_s;
               next_bit_cnt = 3'h0;
               next_phase   = spi_port_pkg::PH_CTRL;
            end
            spi_port_pkg::PH_CTRL: begin
               if (sck_rise) begin
                  next_rx      = rx_full;
                  next_bit_cnt = bit_cnt + 3'h1;
                  if (bit_cnt == 3'h7) begin
                     next_is_read   = (rx[6] == spi_port_pkg::DIR_READ);
                     next_addr      = rx_full[6:0];
                     next_hold_addr = (rx_full[6:0] == spi_port_pkg::FIFO_DATA_ADDR);
                     next_fetch     = (rx[6] == spi_port_pkg::DIR_READ);
                     next_phase     = spi_port_pkg::PH_DATA;
                  end
               end
            end
            spi_port_pkg::PH_DATA: begin
               if (sck_fall && is_read) begin
                  // same drive timing for both wirings
                  next_drive   = 1'b1;
                  next_out_bit = tx[7];
                  next_tx      = {tx[6:0], 1'b0};
               end
               if (sck_rise) begin
                  next_rx      = rx_full;
                  next_bit_cnt = bit_cnt + 3'h1;
                  if (bit_cnt == 3'h7) begin
                     if (is_read) begin
                        next_fetch = 1'b1;
                        if (!hold_addr) begin
                           next_addr = addr + 7'h01;
                        end
                     end else begin
                        next_wdata    = rx_full;
                        next_wr_pulse = 1'b1;
                        next_phase    = spi_port_pkg::PH_DONE;
                     end
                  end
               end
            end
            spi_port_pkg::PH_DONE: begin
               next_drive = 1'b0;
            end
            default: begin
               next_phase = spi_port_pkg::PH_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         phase      <= spi_port_pkg::PH_IDLE;
         bit_cnt    <= 3'h0;
         rx         <= 8'h00;
         tx         <= 8'h00;
         addr       <= 7'h00;
         wdata      <= 8'h00;
         is_read    <= 1'b0;
         hold_addr  <= 1'b0;
         fetch      <= 1'b0;
         wr_pulse   <= 1'b0;
         drive      <= 1'b0;
         out_bit    <= 1'b0;
         mode3      <= 1'b0;
         three_wire <= spi_port_pkg::THREE_WIRE_RST;
      end else begin
         phase      <= next_phase;
         bit_cnt    <= next_bit_cnt;
         rx         <= next_rx;
         tx         <= next_tx;
         addr       <= next_addr;
         wdata      <= next_wdata;
         is_read    <= next_is_read;
         hold_addr  <= next_hold_addr;
         fetch      <= next_fetch;
         wr_pulse   <= next_wr_pulse;
         drive      <= next_drive;
         out_bit    <= next_out_bit;
         mode3      <= next_mode3;
         three_wire <= next_three_wire;
      end
   end

   // =========================================================
   // outputs
   assign reg_addr          = addr;
   assign reg_wdata         = wdata;
   assign reg_wr            = wr_pulse;
   assign three_wire_enable = three_wire;
   assign link.dev_sdo_out   = out_bit;
   assign link.dev_sdo_oe_n  = !(drive && !three_wire);
   assign link.dev_data_out  = out_bit;
   assign link.dev_data_oe_n = !(drive && three_wire);
endmodule : sensor_spi_device

// >>> src/spi_host_master.sv
/*
 * master end of the serial port: one frame per command, reads may burst.
 * assumes the sensor end shares ref_clk, so returned data needs no synchroniser.
 */
`timescale 1ns/1ps
module spi_host_master #(
   parameter int SCK_HALF = spi_port_pkg::SCK_HALF_CYCLES
) (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // link
   spi_link.host            link,
   // configuration
   input  wire logic        three_wire,
   input  wire logic        mode3,
   // command
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic        cmd_read,
   input  wire logic [6:0]  cmd_addr,
   input  wire logic [7:0]  cmd_wdata,
   input  wire logic [7:0]  cmd_count,
   // answer
   output logic             rsp_valid,
   output logic      [7:0]  rsp_data,
   output logic             done
);
   initial begin
      if (SCK_HALF < 4 || SCK_HALF > 255) $error("sck half period must be 4..255 cycles");
   end

   spi_port_pkg::host_state_e state, next_state;
   logic [7:0]  div, next_div;
   logic [11:0] bit_idx, next_bit_idx, last_bit, next_last_bit;
   logic [15:0] tx, next_tx;
   logic [7:0]  rx, next_rx, next_rsp_data;
   logic        sck, next_sck, csn, next_csn, dout, next_dout, oe_n, next_oe_n;
   logic        rd, next_rd, tw, next_tw, cpol, next_cpol;
   logic        next_rsp_valid, next_done, tick, din;

   assign cmd_ready = (state == spi_port_pkg::H_IDLE);
   assign tick      = (div == 8'h00);
   assign din       = tw ? link.shared_data_pin : link.sdo;

   always_comb begin
      next_state     = state;
      next_div       = tick ? 8'(SCK_HALF - 1) : div - 8'h01;
      next_bit_idx   = bit_idx;
      next_last_bit  = last_bit;
      next_tx        = tx;
      next_rx        = rx;
      next_sck       = sck;
      next_csn       = csn;
      next_dout      = dout;
      next_oe_n      = oe_n;
      next_rd        = rd;
      next_tw        = tw;
      next_cpol      = cpol;
      next_rsp_valid = 1'b0;
      next_rsp_data  = rsp_data;
      next_done      = 1'b0;
      case (state)
         spi_port_pkg::H_IDLE: begin
            next_div = 8'(SCK_HALF - 1);
            next_sck = mode3;
            if (cmd_valid) begin
               next_rd       = cmd_read;
               next_tw       = three_wire;
               next_cpol     = mode3;
               next_tx       = {cmd_read, cmd_addr, cmd_wdata};
               next_bit_idx  = 12'h000;
               next_last_bit = cmd_read ? 12'(8 * ((cmd_count == 8'h00) ? 1 : cmd_count) + 7)
                                        : 12'(spi_port_pkg::FRAME_BITS - 1);
               next_state    = spi_port_pkg::H_SETUP;
            end
         end
         spi_port_pkg::H_SETUP: begin
            if (tick) begin
               next_csn   = 1'b0;
               next_state = spi_port_pkg::H_LEAD;
            end
         end
         spi_port_pkg::H_LEAD, spi_port_pkg::H_HIGH: begin
            if (tick) begin
               if (state == spi_port_pkg::H_HIGH && bit_idx == last_bit) begin
                  next_sck   = cpol;
                  next_state = spi_port_pkg::H_HOLD;
               end else begin
                  if (state == spi_port_pkg::H_HIGH) begin
                     next_bit_idx = bit_idx + 12'h001;
                  end
                  // data changes on the falling edge
                  next_sck   = 1'b0;
                  next_dout  = tx[15];
                  next_tx    = {tx[14:0], 1'b0};
                  next_oe_n  = rd && (next_bit_idx >= 12'(spi_port_pkg::CTRL_BITS));
                  next_state = spi_port_pkg::H_LOW;
               end
            end
         end
         spi_port_pkg::H_LOW: begin
            if (tick) begin
               next_sck   = 1'b1;
               next_state = spi_port_pkg::H_HIGH;
               if (rd && bit_idx >= 12'(spi_port_pkg::CTRL_BITS)) begin
                  next_rx = {rx[6:0], din};
                  if (bit_idx[2:0] == 3'h7) begin
                     next_rsp_valid = 1'b1;
                     next_rsp_data  = {rx[6:0], din};
                  end
               end
            end
         end
         spi_port_pkg::H_HOLD: begin
            if (tick) begin
               next_csn   = 1'b1;
               next_oe_n  = 1'b1;
               next_state = spi_port_pkg::H_GAP;
            end
         end
         spi_port_pkg::H_GAP: begin
            if (tick) begin
               next_done  = 1'b1;
               next_state = spi_port_pkg::H_IDLE;
            end
         end
         default: begin
            next_state = spi_port_pkg::H_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state     <= spi_port_pkg::H_IDLE;
         div       <= 8'h00;
         bit_idx   <= 12'h000;
         last_bit  <= 12'h000;
         tx        <= 16'h0000;
         rx        <= 8'h00;
         sck       <= 1'b0;
         csn       <= 1'b1;
         dout      <= 1'b1;
         oe_n      <= 1'b1;
         rd        <= 1'b0;
         tw        <= 1'b0;
         cpol      <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data  <= 8'h00;
         done      <= 1'b0;
      end else begin
         state     <= next_state;
         div       <= next_div;
         bit_idx   <= next_bit_idx;
         last_bit  <= next_last_bit;
         tx        <= next_tx;
         rx        <= next_rx;
         sck       <= next_sck;
         csn       <= next_csn;
         dout      <= next_dout;
         oe_n      <= next_oe_n;
         rd        <= next_rd;
         tw        <= next_tw;
         cpol      <= next_cpol;
         rsp_valid <= next_rsp_valid;
         rsp_data  <= next_rsp_data;
         done      <= next_done;
      end
   end

   assign link.chip_select_n    = csn;
   assign link.shared_clock_pin = sck;
   assign link.host_data_out    = dout;
   assign link.host_data_oe_n   = oe_n;
endmodule : spi_host_master

// >>> src/spi_link.sv
/*
 * the serial link between master and sensor port.
 * assumes a pull-up on both data lines; a released line reads high.
 */
`timescale 1ns/1ps
interface spi_link;
   logic chip_select_n;
   logic shared_clock_pin;
   logic host_data_out;
   logic host_data_oe_n;
   logic dev_data_out;
   logic dev_data_oe_n;
   logic dev_sdo_out;
   logic dev_sdo_oe_n;
   logic shared_data_pin;
   logic sdo;

   // =========================================================
   // wire resolution with pull-up
   assign shared_data_pin = !dev_data_oe_n ? dev_data_out :
                            !host_data_oe_n ? host_data_out : 1'b1;
   assign sdo = !dev_sdo_oe_n ? dev_sdo_out : 1'b1;

   modport device (input chip_select_n, input shared_clock_pin, input shared_data_pin,
                   output dev_data_out, output dev_data_oe_n,
                   output dev_sdo_out, output dev_sdo_oe_n);
   modport host (output chip_select_n, output shared_clock_pin,
                 output host_data_out, output host_data_oe_n,
                 input shared_data_pin, input sdo);
endinterface : spi_link

// >>> src/spi_port_pkg.sv
/*
 * shared constants and state types for the serial register port and its master.
 * assumes both ends run on one 50 MHz reference clock.
 */
package spi_port_pkg;
   // =========================================================
   // frame layout
   localparam int ADDR_W         = 7;
   localparam int DATA_W         = 8;
   localparam int CTRL_BITS      = 8;
   localparam int FRAME_BITS     = 16;
   localparam logic DIR_WRITE    = 1'b0;
   localparam logic DIR_READ     = 1'b1;
   // =========================================================
   // register addresses and fields
   localparam logic [6:0] THREE_WIRE_ADDR = 7'h34;
   localparam int         THREE_WIRE_BIT  = 0;
   localparam logic [6:0] FIFO_DATA_ADDR  = 7'h3f;
   localparam logic       THREE_WIRE_RST  = 1'b0;
   localparam logic [7:0] EMPTY_READ_VAL  = 8'h00;
   // =========================================================
   // timing
   localparam int CLK_PERIOD_NS   = 20;
   localparam int SCK_PERIOD_NS   = 160;
   localparam int SCK_HALF_CYCLES = SCK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam int FIFO_DEPTH      = 16;
   // =========================================================
   // state types
   typedef enum logic [1:0] {PH_IDLE, PH_CTRL, PH_DATA, PH_DONE} dev_phase_e;
   typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LEAD, H_LOW, H_HIGH, H_HOLD, H_GAP} host_state_e;
endpackage : spi_port_pkg

// >>> tb/sensor_spi_slave_port_test.sv
/*
 * testbench joining master and sensor port over one link.
 * assumes a register file model answers reg_rd combinationally.
 */
`timescale 1ns/1ps
module sensor_spi_slave_port_test;
   logic       ref_clk = 1'b0;
   logic       rstn = 1'b0;
   logic       strap = 1'b0;
   logic       tw = 1'b0;
   logic       m3 = 1'b0;
   logic       cmd_valid = 1'b0;
   logic       cmd_read = 1'b0;
   logic [6:0] cmd_addr = 7'h00;
   logic [7:0] cmd_wdata = 8'h00;
   logic [7:0] cmd_count = 8'h01;
   logic       sample_valid = 1'b0;
   logic [7:0] sample_data = 8'h00;
   logic       cmd_ready, rsp_valid, done, reg_wr, reg_rd, sample_ready;
   logic       spi_selected, three_wire_enable;
   logic [7:0] rsp_data, reg_wdata, reg_rdata;
   logic [6:0] reg_addr;
   logic [7:0] mem [128];
   logic [7:0] got [$];
   int         err_total = 0;
   int         num_checks = 0;
   int         k;
   int         rd_pulses = 0;
   always #10 ref_clk = ~ref_clk;
   assign reg_rdata = mem[reg_addr];
   always @(posedge ref_clk) if (reg_wr === 1'b1) mem[reg_addr] <= reg_wdata;
   always @(posedge ref_clk) if (reg_rd === 1'b1) rd_pulses++;
   // ===============================================================
   // structure
   spi_link link ();
   sensor_spi_device i_sensor_spi_device (.ref_clk(ref_clk), .rstn(rstn), .link(link),
      .interface_select_strap(strap), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
      .sample_ready(sample_ready), .sample_data(sample_data), .spi_selected(spi_selected),
      .three_wire_enable(three_wire_enable));
   spi_host_master i_spi_host_master (.ref_clk(ref_clk), .rstn(rstn), .link(link),
      .three_wire(tw), .mode3(m3), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_read(cmd_read), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_count(cmd_count),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .done(done));
   spi_link_checker i_spi_link_checker (.ref_clk(ref_clk), .rstn(rstn),
      .chip_select_n(link.chip_select_n), .shared_clock_pin(link.shared_clock_pin),
      .shared_data_pin(link.shared_data_pin), .host_data_oe_n(link.host_data_oe_n),
      .dev_data_out(link.dev_data_out), .dev_data_oe_n(link.dev_data_oe_n),
      .dev_sdo_out(link.dev_sdo_out), .dev_sdo_oe_n(link.dev_sdo_oe_n));
   // ===============================================================
   // tasks
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one command, collecting every returned byte until done
   task automatic op(input logic rd, input logic [6:0] a, input logic [7:0] d,
                     input logic [7:0] n);
      got.delete();
      @(negedge ref_clk);
      while (cmd_ready !== 1'b1) @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd_read = rd;
      cmd_addr = a;
      cmd_wdata = d;
      cmd_count = n;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      for (int t = 0; t < 30000 && done !== 1'b1; t++) begin
         @(posedge ref_clk);
         #1;
         if (rsp_valid === 1'b1) got.push_back(rsp_data);
      end
      if (done !== 1'b1) err_total++;
   endtask : op
   // ===============================================================
   // tests
   initial begin
      #400000;
      err_total++;
      complete_run();
   end
   initial begin
      for (int i = 0; i < 128; i++) mem[i] = 8'(i * 7 + 3);
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk) rstn = 1'b1;
      repeat (6) @(negedge ref_clk);
      check({7'h00, three_wire_enable}, 8'h00);
      check({7'h00, spi_selected}, 8'h01);
      op(1'b0, 7'h10, 8'ha5, 8'h01);
      check(mem[7'h10], 8'ha5);
      @(negedge ref_clk) m3 = 1'b1;
      k = rd_pulses;
      op(1'b1, 7'h0e, 8'h00, 8'h03);
      check(8'(got.size()), 8'h03);
      check(8'(rd_pulses - k), 8'h04);
      for (int i = 0; i < 3; i++) check(got[i], mem[7'(14 + i)]);
      op(1'b0, spi_port_pkg::THREE_WIRE_ADDR, 8'h01, 8'h01);
      check({7'h00, three_wire_enable}, 8'h01);
      @(negedge ref_clk);
      tw = 1'b1;
      m3 = 1'b0;
      op(1'b0, 7'h20, 8'h5a, 8'h01);
      op(1'b1, 7'h1f, 8'h00, 8'h02);
      check(got[0], mem[7'h1f]);
      check(got[1], 8'h5a);
      // fill the buffer until it refuses
      k = 0;
      for (int j = 0; j < 20; j++) begin
         @(negedge ref_clk);
         sample_data = 8'h80 + 8'(k);
         sample_valid = 1'b1;
         if (sample_ready === 1'b1) k++;
      end
      @(negedge ref_clk);
      sample_valid = 1'b0;
      check(8'(k), 8'(spi_port_pkg::FIFO_DEPTH));
      k = rd_pulses;
      op(1'b1, spi_port_pkg::FIFO_DATA_ADDR, 8'h00, 8'h11);
      check(8'(rd_pulses - k), 8'h00);
      for (int i = 0; i < 16; i++) check(got[i], 8'h80 + 8'(i));
      check(got[16], spi_port_pkg::EMPTY_READ_VAL);
      check({7'h00, sample_ready}, 8'h01);
      // strap high: port deaf, line stays pulled up
      @(negedge ref_clk) strap = 1'b1;
      repeat (6) @(negedge ref_clk);
      check({7'h00, spi_selected}, 8'h00);
      op(1'b1, 7'h10, 8'h00, 8'h01);
      check(got[0], 8'hff);
      op(1'b0, 7'h10, 8'h3c, 8'h01);
      @(negedge ref_clk) strap = 1'b0;
      repeat (6) @(negedge ref_clk);
      op(1'b1, 7'h10, 8'h00, 8'h01);
      check(got[0], 8'ha5);
      complete_run();
   end
endmodule : sensor_spi_slave_port_test

// >>> tb/spi_link_checker.sv
/*
 * concurrent checks on the serial link between master and sensor port.
 * assumes the master runs a half period of four ref_clk cycles.
 */
`timescale 1ns/1ps
module spi_link_checker (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // link
   input wire logic chip_select_n,
   input wire logic shared_clock_pin,
   input wire logic shared_data_pin,
   input wire logic host_data_oe_n,
   input wire logic dev_data_out,
   input wire logic dev_data_oe_n,
   input wire logic dev_sdo_out,
   input wire logic dev_sdo_oe_n
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   // ===============================================================
   // serial clock rises since select fell, and the direction bit
   logic [7:0] rises;
   logic [7:0] next_rises;
   logic       rw;
   logic       next_rw;
   logic       sck_d;
   logic       rise;
   assign rise = shared_clock_pin && !sck_d;
   always_comb begin
      next_rises = rises;
      next_rw = rw;
      if (chip_select_n) begin
         next_rises = 8'h00;
      end else if (rise && rises != 8'hff) begin
         next_rises = rises + 8'h01;
         if (rises == 8'h00) next_rw = shared_data_pin;
      end
   end
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rises <= 8'h00;
         rw <= 1'b0;
         sck_d <= 1'b0;
      end else begin
         rises <= next_rises;
         rw <= next_rw;
         sck_d <= shared_clock_pin;
      end
   end
   // ===============================================================
   // properties
   sequence lead_s;
      $stable(shared_clock_pin) [*3];
   endsequence
   sequence released_s;
      ##[0:4] (dev_sdo_oe_n && dev_data_oe_n);
   endsequence
   chk_release_after_select: assert property ($rose(chip_select_n) |-> released_s)
      else $error("device still drives after select rose");
   chk_one_data_driver: assert property (!(!dev_data_oe_n && !host_data_oe_n))
      else $error("both ends drive the data pin");
   chk_one_device_out: assert property (!dev_data_oe_n |-> dev_sdo_oe_n)
      else $error("device drives both data outputs");
   chk_lead_clock_steady: assert property ($fell(chip_select_n) |=> lead_s)
      else $error("clock moved right after select fell");
   chk_sdo_change_low: assert property ((!dev_sdo_oe_n && !$past(dev_sdo_oe_n)
      && $changed(dev_sdo_out)) |-> !shared_clock_pin)
      else $error("sdo changed while clock high");
   chk_data_change_low: assert property ((!dev_data_oe_n && !$past(dev_data_oe_n)
      && $changed(dev_data_out)) |-> !shared_clock_pin)
      else $error("data pin changed while clock high");
   chk_ctrl_byte_free: assert property ((!chip_select_n && (!dev_sdo_oe_n || !dev_data_oe_n))
      |-> rises >= 8'h08)
      else $error("device drove during the control byte");
   chk_write_sdo_off: assert property ((!chip_select_n && rises != 8'h00 && !rw)
      |-> dev_sdo_oe_n)
      else $error("sdo driven during a write");
endmodule : spi_link_checker
